// [bench/tb_top.sv]
// Self-checking bench for the shift, subtract and branch execution unit over its register bus
`timescale 1ns/10ps
module tb_top
   import ssbe_pkg::*;
;
   logic i_mclk;
   logic i_rst_n;
   logic [10:0] i_avs_address;
   logic i_avs_read;
   logic i_avs_write;
   logic [31:0] i_avs_writedata;
   logic [3:0] i_avs_byteenable;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest;
   int failures;
   int cmp_count;
   int cycles;
   logic [31:0] q;

   ssbe_exec uut (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest)
   );

   // 100 MHz clock
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Hang guard; the whole sequence needs well under a thousand cycles
   initial
   begin
      cycles = 0;
      forever
      begin
         @(posedge i_mclk);
         cycles++;
         if (cycles > 5000)
         begin
            failures++;
            wrap_up();
         end
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask

   // One bus access; an edge passes first so a request is never raised in the release step
   task automatic bus(input logic rw, input logic [10:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_avs_address <= a;
      i_avs_write <= rw;
      i_avs_read <= ~rw;
      i_avs_writedata <= d;
      do
         @(posedge i_mclk);
      while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask

   task automatic rchk(input logic [10:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask

   task automatic rf(input int i, input logic [7:0] v);
      bus(1'b1, 11'h100 + 11'(4 * i), {24'h0, v});
   endtask

   // Load flags and instruction, start it, check completion status, then clear it
   task automatic run(input logic mode, input logic [31:0] lo, input logic [4:0] fl, input logic [31:0] st);
      bus(1'b1, REG_FLAGS, {27'h0, fl});
      bus(1'b1, REG_INSTR_LO, lo);
      bus(1'b1, REG_INSTR_HI, 32'h0);
      bus(1'b1, REG_CTRL, {30'h0, 1'b1, mode});
      rchk(REG_STATUS, st, 32'h6);
      bus(1'b1, REG_STATUS, 32'h6);
   endtask

   initial
   begin
      failures = 0;
      cmp_count = 0;
      i_rst_n = 1'b0;
      i_avs_address = 11'h0;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_writedata = 32'h0;
      i_avs_byteenable = 4'hf;
      repeat (6) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      rchk(REG_FLAGS, 32'h0, 32'h1f);
      rchk(REG_PC, 32'h0, 32'hffff);
      rchk(11'h020, 32'h0, 32'hffffffff);
      // Forward branch in binary mode, flags all set and kept
      bus(1'b1, REG_PC, 32'h0100);
      run(1'b0, 32'h2180, 5'h1f, 32'h2);
      rchk(REG_PC, 32'h0123, 32'hffff);
      rchk(REG_FLAGS, 32'h1f, 32'h1f);
      // Furthest backward reach
      bus(1'b1, REG_PC, 32'h0100);
      run(1'b1, 32'h8080, 5'h00, 32'h2);
      rchk(REG_PC, 32'h0082, 32'hffff);
      // Escape in front of a plain opcode is refused
      run(1'b0, 32'h80a5, 5'h00, 32'h6);
      // Left shift with escape in binary mode
      rf(1, 8'hc5);
      run(1'b0, 32'h103ea5, 5'h00, 32'h2);
      rchk(11'h104, 32'h8a, 32'hff);
      rchk(REG_FLAGS, 32'h09, 32'h1f);
      // Arithmetic right shift, source mode, no escape
      rf(1, 8'hc5);
      run(1'b1, 32'h100e, 5'h00, 32'h2);
      rchk(11'h104, 32'he2, 32'hff);
      rchk(REG_FLAGS, 32'h09, 32'h1f);
      // Byte logical right shift clears the top bit
      rf(1, 8'hc5);
      run(1'b1, 32'h101e, 5'h00, 32'h2);
      rchk(11'h104, 32'h62, 32'hff);
      rchk(REG_FLAGS, 32'h01, 32'h1f);
      // Word logical right shift on the pair at RF 2 and 3
      rf(2, 8'h81);
      rf(3, 8'h01);
      run(1'b1, 32'h141e, 5'h00, 32'h2);
      rchk(11'h108, 32'h40, 32'hff);
      rchk(11'h10c, 32'h80, 32'hff);
      rchk(REG_FLAGS, 32'h01, 32'h1f);
      // Word subtract keeps a preset aux carry
      rf(0, 8'h00);
      rf(1, 8'h01);
      rf(2, 8'h01);
      rf(3, 8'h00);
      run(1'b1, 32'h109d, 5'h02, 32'h2);
      rchk(11'h10c, 32'hff, 32'hff);
      rchk(REG_FLAGS, 32'h02, 32'h1f);
      // Byte register subtract with signed overflow
      rf(1, 8'hc9);
      rf(0, 8'h54);
      run(1'b1, 32'h109c, 5'h1f, 32'h2);
      rchk(11'h104, 32'h75, 32'hff);
      rchk(REG_FLAGS, 32'h04, 32'h1f);
      // Accumulator subtract with incoming borrow, binary mode
      rf(11, 8'hc9);
      rf(2, 8'h54);
      run(1'b0, 32'h9a, 5'h01, 32'h2);
      rchk(11'h12c, 32'h74, 32'hff);
      rchk(REG_FLAGS, 32'h04, 32'h1f);
      // Borrow out of bit 3 and bit 7
      rf(11, 8'h10);
      rf(2, 8'h01);
      run(1'b0, 32'h9a, 5'h01, 32'h2);
      rchk(11'h12c, 32'h0e, 32'hff);
      rchk(REG_FLAGS, 32'h02, 32'h1f);
      rf(11, 8'h00);
      run(1'b0, 32'h9a, 5'h00, 32'h2);
      rchk(REG_FLAGS, 32'h0b, 32'h1f);
      // Extended shift without escape in binary mode is refused and leaves the register alone
      rf(1, 8'hc5);
      run(1'b0, 32'h103e, 5'h00, 32'h6);
      rchk(11'h104, 32'hc5, 32'hff);
      // Bit set at byte 20h, bit 3, flags kept
      bus(1'b1, 11'h480, 32'h0);
      run(1'b0, 32'h20d3a9a5, 5'h1f, 32'h2);
      rchk(11'h480, 32'h08, 32'hff);
      rchk(REG_FLAGS, 32'h1f, 32'h1f);
      // Borrow subtract from a direct byte
      rf(11, 8'h10);
      run(1'b0, 32'h2095, 5'h00, 32'h2);
      rchk(11'h12c, 32'h08, 32'hff);
      // Word immediate subtract, high byte first
      rf(2, 8'h00);
      rf(3, 8'hff);
      run(1'b1, 32'h0100149e, 5'h00, 32'h2);
      rchk(11'h10c, 32'hfe, 32'hff);
      // Byte register minus memory through a word register pointer
      rf(0, 8'h00);
      rf(1, 8'h20);
      run(1'b1, 32'h0010099e, 5'h00, 32'h2);
      rchk(11'h104, 32'h18, 32'hff);
      // Byte register minus a direct byte
      run(1'b1, 32'h0020119e, 5'h00, 32'h2);
      rchk(11'h104, 32'h10, 32'hff);
      wrap_up();
   end
endmodule

// [rtl/ssbe_exec.sv]
// Execution unit for bit set, short branch, shifts and subtraction, with Avalon-MM registers
`timescale 1ns/10ps
module ssbe_exec
   import ssbe_pkg::*;
#(
   parameter int DM_AW = DM_AW_DEF
)
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [10:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);
   ssbe_state_e state;
   logic [7:0] rf [RF_BYTES];
   logic [7:0] dm [2**DM_AW];
   logic src_mode;
   logic [4:0] flags;
   logic [15:0] pc;
   logic [63:0] instr;
   logic done;
   logic illegal;
   logic rd_ack;
   logic wr_ack;
   logic exec;
   logic go;
   logic rf_hit;
   logic dm_hit;
   logic [31:0] wmask;
   logic [31:0] rd_mux;
   logic [7:0] ib [8];
   logic [7:0] ob [7];
   logic esc;
   logic ext_ok;
   logic op_br;
   logic op_bs;
   logic op_sll;
   logic op_sra;
   logic op_srl;
   logic op_sub;
   logic op_minus_with_borrow_op;
   logic op_bad;
   ssbe_size_e size;
   logic [5:0] d_idx;
   logic [31:0] a_val;
   logic [31:0] b_val;
   logic [31:0] ind;
   logic [DM_AW-1:0] m_adr;
   logic [2:0] bpos;
   logic [31:0] sh_res;
   logic sh_cy;
   logic sh_n;
   logic sh_z;
   logic [31:0] s_diff;
   logic s_cy;
   logic s_ac;
   logic s_ov;
   logic s_n;
   logic s_z;
   logic [31:0] res;
   logic [15:0] br_target;

   // Register index of a byte, word or dword register field
   function automatic logic [5:0] ridx(input logic [3:0] n, input ssbe_size_e s);
      logic [5:0] r;
      r = {2'b00, n};
      if (s == SZ_W)
         r = {1'b0, n, 1'b0};
      else if (s == SZ_D)
         r = {n, 2'b00};
      return r;
   endfunction

   // Big-endian read of a register, zero extended
   function automatic logic [31:0] rf_rd(input logic [5:0] i, input ssbe_size_e s);
      logic [31:0] v;
      v = {24'h0, rf[i]};
      if (s == SZ_W)
         v = {16'h0000, rf[i], rf[i + 6'd1]};
      else if (s == SZ_D)
         v = {rf[i], rf[i + 6'd1], rf[i + 6'd2], rf[i + 6'd3]};
      return v;
   endfunction

   // Bus handshake: an access completes in the cycle waitrequest is low
   assign rd_ack = i_avs_read & ~o_avs_waitrequest;
   assign wr_ack = i_avs_write & ~o_avs_waitrequest;
   assign rf_hit = (i_avs_address[10:8] == RF_PAGE);
   assign dm_hit = i_avs_address[10];
   assign exec = (state == ST_EXEC);
   assign go = wr_ack & (i_avs_address == REG_CTRL) & i_avs_byteenable[0]
      & i_avs_writedata[CTRL_GO] & (state == ST_IDLE);

   // Byte lane masks and instruction byte views
   generate
      for (genvar g = 0; g < 8; g++)
      begin : g_bytes
         assign ib[g] = instr[8*g +: 8];
         if (g < 4)
         begin : g_lane
            assign wmask[8*g +: 8] = {8{i_avs_byteenable[g]}};
         end
         if (g < 7)
         begin : g_op
            assign ob[g] = esc ? ib[g+1] : ib[g];
         end
      end
   endgenerate

   assign esc = (ib[0] == OPC_ESCAPE);
   // Extended forms need the escape in binary mode and refuse it in source mode
   assign ext_ok = src_mode ? ~esc : esc;

   // Waitrequest drops for exactly one cycle per access
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         o_avs_waitrequest <= 1'b1;
      else if ((i_avs_read | i_avs_write) & o_avs_waitrequest)
         o_avs_waitrequest <= 1'b0;
      else
         o_avs_waitrequest <= 1'b1;
   end

   // Read mux; unmapped offsets read as zero
   always_comb
   begin
      rd_mux = 32'h0;
      if (dm_hit)
         rd_mux = {24'h0, dm[i_avs_address[DM_AW+1:2]]};
      else if (rf_hit)
         rd_mux = {24'h0, rf[i_avs_address[7:2]]};
      else
      begin
         case (i_avs_address)
            REG_CTRL: rd_mux = {31'h0, src_mode};
            REG_STATUS: rd_mux = {29'h0, illegal, done, exec};
            REG_FLAGS: rd_mux = {27'h0, flags};
            REG_PC: rd_mux = {16'h0000, pc};
            REG_INSTR_LO: rd_mux = instr[31:0];
            REG_INSTR_HI: rd_mux = instr[63:32];
            default: rd_mux = 32'h0;
         endcase
      end
   end

   // Read data is captured while waitrequest is still high, so it stands at the ack edge
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         o_avs_readdata <= 32'h0;
      else if (i_avs_read & o_avs_waitrequest)
         o_avs_readdata <= rd_mux;
   end

   // Control: mode and instruction bytes
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         src_mode <= 1'b0;
         instr <= 64'h0;
      end
      else if (wr_ack)
      begin
         if (i_avs_address == REG_CTRL && i_avs_byteenable[0])
            src_mode <= i_avs_writedata[CTRL_SRC_MODE];
         if (i_avs_address == REG_INSTR_LO)
            instr[31:0] <= (instr[31:0] & ~wmask) | (i_avs_writedata & wmask);
         if (i_avs_address == REG_INSTR_HI)
            instr[63:32] <= (instr[63:32] & ~wmask) | (i_avs_writedata & wmask);
      end
   end

   // Sequencer: one execute cycle per start
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         state <= ST_IDLE;
      else
      begin
         case (state)
            ST_IDLE: state <= go ? ST_EXEC : ST_IDLE;
            ST_EXEC: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Sticky completion flags; a hardware set beats a software clear
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         done <= 1'b0;
         illegal <= 1'b0;
      end
      else
      begin
         if (exec)
            done <= 1'b1;
         else if (wr_ack && i_avs_address == REG_STATUS && i_avs_writedata[STS_DONE])
            done <= 1'b0;
         if (exec && op_bad)
            illegal <= 1'b1;
         else if (wr_ack && i_avs_address == REG_STATUS && i_avs_writedata[STS_ILLEGAL])
            illegal <= 1'b0;
      end
   end

   // Decode and operand fetch
   always_comb
   begin
      op_br = 1'b0;
      op_bs = 1'b0;
      op_sll = 1'b0;
      op_sra = 1'b0;
      op_srl = 1'b0;
      op_sub = 1'b0;
      op_minus_with_borrow_op = 1'b0;
      op_bad = 1'b0;
      size = SZ_B;
      d_idx = 6'h00;
      b_val = 32'h0;
      ind = 32'h0;
      m_adr = '0;
      bpos = ob[1][2:0];
      if (ob[0] == OPC_BRANCH && !esc)
         op_br = 1'b1;
      else if (ob[0] == OPC_MINUS_WITH_BORROW_OP_IMM && !esc)
      begin
         op_minus_with_borrow_op = 1'b1;
         d_idx = ACC_INDEX;
         b_val = {24'h0, ob[1]};
      end
      else if (ob[0] == OPC_MINUS_WITH_BORROW_OP_DIR && !esc)
      begin
         op_minus_with_borrow_op = 1'b1;
         d_idx = ACC_INDEX;
         m_adr = ob[1][DM_AW-1:0];
         b_val = {24'h0, dm[m_adr]};
      end
      else if (ob[0][7:3] == OPC_MINUS_WITH_BORROW_OP_RN && !ext_ok)
      begin
         op_minus_with_borrow_op = 1'b1;
         d_idx = ACC_INDEX;
         b_val = {24'h0, rf[{3'b000, ob[0][2:0]}]};
      end
      else if (!ext_ok)
         op_bad = 1'b1;
      else
      begin
         case (ob[0])
            OPC_BITSET:
            begin
               op_bs = (ob[1][7:4] == BITSET_NIB) && !ob[1][3];
               op_bad = !op_bs;
               m_adr = ob[2][DM_AW-1:0];
            end
            OPC_SLL, OPC_SRA, OPC_SRL:
            begin
               size = (ob[1][3:0] == SH_WORD) ? SZ_W : SZ_B;
               op_bad = (ob[1][3:0] != SH_WORD) && (ob[1][3:0] != SH_BYTE);
               op_sll = !op_bad && (ob[0] == OPC_SLL);
               op_sra = !op_bad && (ob[0] == OPC_SRA);
               op_srl = !op_bad && (ob[0] == OPC_SRL);
               d_idx = ridx(ob[1][7:4], size);
            end
            OPC_SUB_RR_B, OPC_SUB_RR_W, OPC_SUB_RR_D:
            begin
               op_sub = 1'b1;
               size = (ob[0] == OPC_SUB_RR_W) ? SZ_W : (ob[0] == OPC_SUB_RR_D) ? SZ_D : SZ_B;
               d_idx = ridx(ob[1][7:4], size);
               b_val = rf_rd(ridx(ob[1][3:0], size), size);
            end
            OPC_SUB_MISC:
            begin
               op_sub = 1'b1;
               d_idx = ridx(ob[1][7:4], SZ_B);
               case (ob[1][3:0])
                  SM_IMM_B: b_val = {24'h0, ob[2]};
                  SM_IMM_W, SM_IMM_D:
                  begin
                     size = (ob[1][3:0] == SM_IMM_W) ? SZ_W : SZ_D;
                     d_idx = ridx(ob[1][7:4], size);
                     b_val = {16'h0000, ob[2], ob[3]};
                  end
                  SM_DIR8_B, SM_DIR16_B, SM_DIR8_W, SM_DIR16_W:
                  begin
                     size = ob[1][2] ? SZ_W : SZ_B;
                     d_idx = ridx(ob[1][7:4], size);
                     m_adr = ob[1][1] ? ob[3][DM_AW-1:0] : ob[2][DM_AW-1:0];
                     b_val = ob[1][2] ? {16'h0000, dm[m_adr], dm[m_adr + 1'b1]} : {24'h0, dm[m_adr]};
                  end
                  SM_IND_W, SM_IND_D:
                  begin
                     op_bad = (ob[2][3:0] != 4'h0);
                     op_sub = !op_bad;
                     d_idx = ridx(ob[2][7:4], SZ_B);
                     if (ob[1][3:0] == SM_IND_W)
                        ind = rf_rd(ridx(ob[1][7:4], SZ_W), SZ_W);
                     else
                        ind = rf_rd(ridx(ob[1][7:4], SZ_D), SZ_D);
                     m_adr = ind[DM_AW-1:0];
                     b_val = {24'h0, dm[m_adr]};
                  end
                  default:
                  begin
                     op_sub = 1'b0;
                     op_bad = 1'b1;
                  end
               endcase
            end
            default: op_bad = 1'b1;
         endcase
      end
   end

   // Destination doubles as minuend and shift operand
   assign a_val = rf_rd(d_idx, size);

   ssbe_subtract u_sub (
      .i_min(a_val),
      .i_sub(b_val),
      .i_borrow(op_minus_with_borrow_op & flags[FLG_CY]),
      .i_size(size),
      .o_diff(s_diff),
      .o_cy(s_cy),
      .o_ac(s_ac),
      .o_ov(s_ov),
      .o_n(s_n),
      .o_z(s_z)
   );

   // Single-bit shifts; operand is zero extended so the logical right shift fills zero
   always_comb
   begin
      if (op_sll)
      begin
         sh_res = (a_val << 1) & ((size == SZ_W) ? 32'h0000ffff : 32'h000000ff);
         sh_cy = (size == SZ_W) ? a_val[15] : a_val[7];
      end
      else
      begin
         sh_res = a_val >> 1;
         sh_cy = a_val[0];
         if (op_sra)
            sh_res = sh_res | ((size == SZ_W) ? {16'h0000, a_val[15], 15'h0000} : {24'h0, a_val[7], 7'h00});
      end
      sh_n = (size == SZ_W) ? sh_res[15] : sh_res[7];
      sh_z = (sh_res == 32'h0);
   end

   assign res = (op_sub | op_minus_with_borrow_op) ? s_diff : sh_res;
   // Displacement is sign extended so the reach is -128..+127 from the next instruction
   assign br_target = pc + BRANCH_LEN + {{8{ob[1][7]}}, ob[1]};

   // Register file: execute write-back or bus write
   always_ff @(posedge i_mclk)
   begin
      if (exec && (op_sub | op_minus_with_borrow_op | op_sll | op_sra | op_srl))
      begin
         case (size)
            SZ_W:
            begin
               rf[d_idx] <= res[15:8];
               rf[d_idx + 6'd1] <= res[7:0];
            end
            SZ_D:
            begin
               rf[d_idx] <= res[31:24];
               rf[d_idx + 6'd1] <= res[23:16];
               rf[d_idx + 6'd2] <= res[15:8];
               rf[d_idx + 6'd3] <= res[7:0];
            end
            default: rf[d_idx] <= res[7:0];
         endcase
      end
      else if (wr_ack && rf_hit && i_avs_byteenable[0])
         rf[i_avs_address[7:2]] <= i_avs_writedata[7:0];
   end

   // Data memory: bit set or bus write
   always_ff @(posedge i_mclk)
   begin
      if (exec && op_bs)
         dm[m_adr][bpos] <= 1'b1;
      else if (wr_ack && dm_hit && i_avs_byteenable[0])
         dm[i_avs_address[DM_AW+1:2]] <= i_avs_writedata[7:0];
   end

   // Flags; branch and bit set leave them alone
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         flags <= FLAGS_RST;
      else if (exec && (op_sll | op_sra | op_srl))
      begin
         flags[FLG_CY] <= sh_cy;
         flags[FLG_N] <= sh_n;
         flags[FLG_Z] <= sh_z;
      end
      else if (exec && (op_sub | op_minus_with_borrow_op))
      begin
         flags[FLG_CY] <= s_cy;
         flags[FLG_OV] <= s_ov;
         flags[FLG_N] <= s_n;
         flags[FLG_Z] <= s_z;
         if (size == SZ_B)
            flags[FLG_AC] <= s_ac;
      end
      else if (wr_ack && i_avs_address == REG_FLAGS && i_avs_byteenable[0])
         flags <= i_avs_writedata[4:0];
   end

   // Program counter: only the short branch or a bus write to REG_PC moves it
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         pc <= PC_RST;
      else if (exec && op_br)
         pc <= br_target;
      else if (wr_ack && i_avs_address == REG_PC)
         pc <= (pc & ~wmask[15:0]) | (i_avs_writedata[15:0] & wmask[15:0]);
   end

   property p_br_flags;
      @(posedge i_mclk) disable iff (!i_rst_n) exec && op_br |=> flags == $past(flags);
   endproperty
   a_br_flags: assert property (p_br_flags) else $error("branch changed flags");

   property p_br_pc;
      @(posedge i_mclk) disable iff (!i_rst_n)
         exec && op_br |=> pc == $past(pc) + 16'h0002 + {{8{$past(ob[1][7])}}, $past(ob[1])};
   endproperty
   a_br_pc: assert property (p_br_pc) else $error("branch target wrong");

   property p_esc;
      @(posedge i_mclk) disable iff (!i_rst_n)
         exec && ob[0] == OPC_SLL && (src_mode == esc) |=> illegal && done;
   endproperty
   a_esc: assert property (p_esc) else $error("escape rule not enforced");

   property p_sll_cy;
      @(posedge i_mclk) disable iff (!i_rst_n)
         exec && op_sll && size == SZ_B |=> flags[FLG_CY] == $past(a_val[7]) && !rf[$past(d_idx)][0];
   endproperty
   a_sll_cy: assert property (p_sll_cy) else $error("left shift carry wrong");

   property p_sra;
      @(posedge i_mclk) disable iff (!i_rst_n)
         exec && op_sra && size == SZ_B |=> rf[$past(d_idx)][7] == $past(a_val[7]) && flags[FLG_CY] == $past(a_val[0]);
   endproperty
   a_sra: assert property (p_sra) else $error("arithmetic shift wrong");

   property p_srl;
      @(posedge i_mclk) disable iff (!i_rst_n)
         exec && op_srl && size == SZ_B |=> !rf[$past(d_idx)][7] && rf[$past(d_idx)][6] == $past(a_val[7]);
   endproperty
   a_srl: assert property (p_srl) else $error("logical right shift wrong");

   property p_ac_keep;
      @(posedge i_mclk) disable iff (!i_rst_n)
         exec && op_sub && size != SZ_B |=> $stable(flags[FLG_AC]);
   endproperty
   a_ac_keep: assert property (p_ac_keep) else $error("aux carry changed on wide subtract");

   property p_minus_with_borrow_op_cy;
      @(posedge i_mclk) disable iff (!i_rst_n)
         exec && op_minus_with_borrow_op |=> flags[FLG_CY] == ($past({1'b0, a_val[7:0]}) < $past({1'b0, b_val[7:0]}) + $past(flags[FLG_CY]));
   endproperty
   a_minus_with_borrow_op_cy: assert property (p_minus_with_borrow_op_cy) else $error("borrow subtract carry wrong");

   property p_bitset;
      @(posedge i_mclk) disable iff (!i_rst_n) exec && op_bs |=> dm[$past(m_adr)][$past(bpos)] && $stable(flags);
   endproperty
   a_bitset: assert property (p_bitset) else $error("bit not set");
endmodule

// [rtl/ssbe_pkg.sv]
// Constants and types shared by the shift, subtract and branch execution unit
// Functional notes
// - Binary mode needs escape byte; source mode not
// - Branch adds signed offset to PC plus two
// - Branch reaches -128..+127, unconditional, flags unchanged
// - Left shift inserts zero, carry gets top bit
// - Arithmetic right shift keeps MSB, carry gets bit0
// - Logical right shift inserts zero, carry gets bit0
// - Byte logical right shift clears bit 7
// - Subtract carry is borrow out of top bit
// - Flag bits 7/6 mean top byte's bits
// - Word/dword subtract keeps aux carry unchanged
// - Byte register subtract uses 9C, writes destination
// - Word 9D, dword 9F register subtract forms
// - Immediate subtract 9E low nibble 0/4/8
// - Direct subtract 9E low nibble 1/5/3/7
// - Indirect byte subtract via word/dword register
// - Borrow subtract removes source and carry from accumulator
// - Borrow subtract carry is borrow from bit 7
// - Borrow subtract aux carry is borrow from bit 3
// - Overflow is borrow out of bit6 xor bit7
// - Borrow subtract supports direct 8-bit address operand
package ssbe_pkg;
   localparam logic [7:0] OPC_ESCAPE = 8'ha5;
   localparam logic [7:0] OPC_BRANCH = 8'h80;
   localparam logic [7:0] OPC_BITSET = 8'ha9;
   localparam logic [3:0] BITSET_NIB = 4'hd;
   localparam logic [7:0] OPC_SLL = 8'h3e;
   localparam logic [7:0] OPC_SRA = 8'h0e;
   localparam logic [7:0] OPC_SRL = 8'h1e;
   localparam logic [7:0] OPC_SUB_RR_B = 8'h9c;
   localparam logic [7:0] OPC_SUB_RR_W = 8'h9d;
   localparam logic [7:0] OPC_SUB_RR_D = 8'h9f;
   localparam logic [7:0] OPC_SUB_MISC = 8'h9e;
   localparam logic [7:0] OPC_MINUS_WITH_BORROW_OP_IMM = 8'h94;
   localparam logic [7:0] OPC_MINUS_WITH_BORROW_OP_DIR = 8'h95;
   localparam logic [4:0] OPC_MINUS_WITH_BORROW_OP_RN = 5'h13;
   // Low nibble of the second byte of the 9E group
   localparam logic [3:0] SM_IMM_B = 4'h0;
   localparam logic [3:0] SM_DIR8_B = 4'h1;
   localparam logic [3:0] SM_DIR16_B = 4'h3;
   localparam logic [3:0] SM_IMM_W = 4'h4;
   localparam logic [3:0] SM_DIR8_W = 4'h5;
   localparam logic [3:0] SM_DIR16_W = 4'h7;
   localparam logic [3:0] SM_IMM_D = 4'h8;
   localparam logic [3:0] SM_IND_W = 4'h9;
   localparam logic [3:0] SM_IND_D = 4'hb;
   localparam logic [3:0] SH_BYTE = 4'h0;
   localparam logic [3:0] SH_WORD = 4'h4;
   localparam logic [5:0] ACC_INDEX = 6'h0b;
   localparam logic [15:0] BRANCH_LEN = 16'h0002;
   // Flag register layout
   localparam int FLG_CY = 0;
   localparam int FLG_AC = 1;
   localparam int FLG_OV = 2;
   localparam int FLG_N = 3;
   localparam int FLG_Z = 4;
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam logic [15:0] PC_RST = 16'h0000;
   // Register map, byte addresses
   localparam logic [10:0] REG_CTRL = 11'h000;
   localparam logic [10:0] REG_STATUS = 11'h004;
   localparam logic [10:0] REG_FLAGS = 11'h008;
   localparam logic [10:0] REG_PC = 11'h00c;
   localparam logic [10:0] REG_INSTR_LO = 11'h010;
   localparam logic [10:0] REG_INSTR_HI = 11'h014;
   localparam logic [2:0] RF_PAGE = 3'h1;
   localparam int CTRL_SRC_MODE = 0;
   localparam int CTRL_GO = 1;
   localparam int STS_BUSY = 0;
   localparam int STS_DONE = 1;
   localparam int STS_ILLEGAL = 2;
   localparam int RF_BYTES = 64;
   localparam int DM_AW_DEF = 8;
   typedef enum logic [1:0] {SZ_B = 2'h0, SZ_W = 2'h1, SZ_D = 2'h2} ssbe_size_e;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} ssbe_state_e;
endpackage

// [rtl/ssbe_subtract.sv]
// Subtractor with borrow and flag generation for byte, word and dword operands
`timescale 1ns/10ps
module ssbe_subtract
   import ssbe_pkg::*;
(
   input wire logic [31:0] i_min,
   input wire logic [31:0] i_sub,
   input wire logic i_borrow,
   input wire ssbe_size_e i_size,
   output logic [31:0] o_diff,
   output logic o_cy,
   output logic o_ac,
   output logic o_ov,
   output logic o_n,
   output logic o_z
);
   logic [8:0] d8;
   logic [16:0] d16;
   logic [32:0] d32;
   logic [4:0] dlo;
   logic ma;
   logic mb;
   logic mr;

   // One extra bit on each width catches the borrow out of the top bit
   assign d8 = {1'b0, i_min[7:0]} - {1'b0, i_sub[7:0]} - {8'h00, i_borrow};
   assign d16 = {1'b0, i_min[15:0]} - {1'b0, i_sub[15:0]} - {16'h0000, i_borrow};
   assign d32 = {1'b0, i_min} - {1'b0, i_sub} - {32'h0, i_borrow};
   assign dlo = {1'b0, i_min[3:0]} - {1'b0, i_sub[3:0]} - {4'h0, i_borrow};

   // Width select; carry, sign and overflow refer to the top bit of the operand width
   always_comb
   begin
      case (i_size)
         SZ_W:
         begin
            o_diff = {16'h0000, d16[15:0]};
            o_cy = d16[16];
            ma = i_min[15];
            mb = i_sub[15];
            mr = d16[15];
            o_z = (d16[15:0] == 16'h0000);
         end
         SZ_D:
         begin
            o_diff = d32[31:0];
            o_cy = d32[32];
            ma = i_min[31];
            mb = i_sub[31];
            mr = d32[31];
            o_z = (d32[31:0] == 32'h0);
         end
         default:
         begin
            o_diff = {24'h0, d8[7:0]};
            o_cy = d8[8];
            ma = i_min[7];
            mb = i_sub[7];
            mr = d8[7];
            o_z = (d8[7:0] == 8'h00);
         end
      endcase
      o_ac = dlo[4];
      // Same as borrow into the top bit differing from borrow out of it
      o_ov = (ma ^ mb) & (ma ^ mr);
      o_n = mr;
   end
endmodule
